// ==== dv/tb.sv ====
// self-checking bench of the far-address move, or and rotate datapath
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((ex) !== (got)) begin \
  bad_count++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb;
  import lamora_pkg::*;

  // one expected retirement of an op
  typedef struct packed {
    logic [7:0] acc;
    logic       zf;
    logic       cf;
    logic       we;
    logic [7:0] wd;
  } lamora_exp_t;

  logic        sys_clk, rst_n, op_valid, ext_wr_en, ext_carry, ext_zero;
  lamora_op_t  op;
  logic [7:0]  mem_rdata, ext_acc, accumulator, mem_wdata;
  logic        zero_flag, carry_flag, mem_we, op_done;
  int          bad_count, total_checks, cycles, i;
  lamora_exp_t exp_q[$];
  lamora_exp_t e;
  logic [7:0]  m_acc, m_wd, mem_b;
  logic        m_zf, m_cf;

  lamora_datapath u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op),
    .mem_rdata(mem_rdata), .ext_wr_en(ext_wr_en), .ext_acc(ext_acc),
    .ext_carry(ext_carry), .ext_zero(ext_zero), .accumulator(accumulator),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .op_done(op_done)
  );

  // 25 MHz core clock
  always #20 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // drivers: run_op notes what each op must leave behind
  // ----------------------------------------------------------------
  task automatic run_op(lamora_op_t o, logic [7:0] m, logic clash);
    lamora_exp_t x;
    @(posedge sys_clk);
    op_valid  <= 1'b1;
    op        <= o;
    mem_rdata <= m;
    ext_wr_en <= clash; // a load beside an op must be ignored
    ext_acc   <= 8'($urandom);
    ext_carry <= 1'($urandom);
    ext_zero  <= 1'($urandom);
    x.we = 1'b0;
    case (o)
      OP_FAR_MOVE_TO_ACC: m_acc = m;
      OP_FAR_MOVE_TO_MEM: begin
        x.we = 1'b1;
        m_wd = m_acc;
      end
      OP_FAR_OR_TO_ACCUMULATOR: begin
        m_acc = m_acc | m;
        m_zf  = (m_acc == 8'h00);
      end
      OP_FAR_OR_TO_MEMORY: begin
        x.we = 1'b1;
        m_wd = m_acc | m;
        m_zf = (m_wd == 8'h00);
      end
      OP_FAR_ROTATE_LEFT: begin
        x.we = 1'b1;
        m_wd = {m[6:0], m[7]};
      end
      OP_FAR_ROTATE_LEFT_TO_ACCUMULATOR: m_acc = {m[6:0], m[7]};
      OP_FAR_ROTATE_LEFT_THROUGH_CARRY: begin
        x.we = 1'b1;
        m_wd = {m[6:0], m_cf};
        m_cf = m[7];
      end
      OP_FAR_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: begin
        m_acc = {m[6:0], m_cf};
        m_cf  = m[7];
      end
      default: ;
    endcase
    if (x.we) mem_b = m_wd; // memory sees the write before the next op
    x.acc = m_acc;
    x.zf  = m_zf;
    x.cf  = m_cf;
    x.wd  = m_wd;
    if (o != OP_NONE) exp_q.push_back(x);
  endtask

  task automatic ext_load(logic [7:0] a, logic c, logic z);
    @(posedge sys_clk);
    op_valid  <= 1'b0;
    ext_wr_en <= 1'b1;
    ext_acc   <= a;
    ext_carry <= c;
    ext_zero  <= z;
    m_acc = a;
    m_cf  = c;
    m_zf  = z;
  endtask

  task automatic idle(int n);
    @(posedge sys_clk);
    op_valid  <= 1'b0;
    ext_wr_en <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  // reset values, looked at where the release edge has settled
  task automatic reset_and_check();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK("accumulator", ACC_RST, accumulator)
    `CHK("zero_flag", ZF_RST, zero_flag)
    `CHK("carry_flag", CF_RST, carry_flag)
    `CHK("mem_wdata", WDATA_RST, mem_wdata)
    `CHK("op_done", 1'b0, op_done)
    m_acc = ACC_RST;
    m_zf  = ZF_RST;
    m_cf  = CF_RST;
    m_wd  = WDATA_RST;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // monitor: each retirement takes the oldest note off the queue
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1) begin
      if (op_done === 1'b1) begin
        `CHK("note present", 1'b1, exp_q.size() > 0)
        if (exp_q.size() > 0) begin
          e = exp_q.pop_front();
          `CHK("accumulator", e.acc, accumulator)
          `CHK("zero_flag", e.zf, zero_flag)
          `CHK("carry_flag", e.cf, carry_flag)
          `CHK("mem_we", e.we, mem_we)
          `CHK("mem_wdata", e.wd, mem_wdata)
        end
      end else begin
        `CHK("mem_we idle", 1'b0, mem_we)
      end
    end
  end

  // hang guard, far above the under one thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      $display("ERROR timeout expected done seen hang");
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    {sys_clk, rst_n, op_valid, ext_wr_en, ext_carry, ext_zero} = '0;
    op = OP_NONE;
    {mem_rdata, ext_acc, bad_count, total_checks, cycles} = '0;
    mem_b = 8'h00;
    void'($urandom(32'h1266C999));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    m_acc = ACC_RST;
    {m_zf, m_cf, m_wd} = {ZF_RST, CF_RST, WDATA_RST};
    // zero flag set and cleared, carry rotates with both carry values
    ext_load(8'h00, 1'b0, 1'b0);
    run_op(OP_FAR_OR_TO_ACCUMULATOR, 8'h00, 1'b0);
    run_op(OP_FAR_OR_TO_MEMORY, 8'h40, 1'b0);
    run_op(OP_FAR_ROTATE_LEFT_THROUGH_CARRY, 8'h81, 1'b0);
    run_op(OP_FAR_ROTATE_LEFT_CARRY_TO_ACCUMULATOR, 8'h81, 1'b1);
    run_op(OP_NONE, 8'hFF, 1'b0);
    // random back-to-back stream over every op, loads mixed in
    for (i = 0; i < 600; i++) begin
      if ($urandom % 8 == 0)
        ext_load(8'($urandom), 1'($urandom), 1'($urandom));
      if ($urandom % 4 == 0)
        mem_b = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
      run_op(lamora_op_t'(4'(1 + $urandom % 8)), mem_b,
             1'($urandom % 6 == 0));
    end
    idle(3);
    reset_and_check();
    run_op(OP_FAR_ROTATE_LEFT, 8'h80, 1'b0);
    run_op(OP_FAR_MOVE_TO_MEM, 8'h01, 1'b0);
    idle(3);
    `CHK("notes left", 0, exp_q.size())
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ==== inc/lamora_pkg.sv ====
// shared constants and types of the far-address move, or and rotate datapath
package lamora_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned TOP_BIT = 7;
  localparam int unsigned LOW_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and the all-zero compare byte
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic       ZF_RST    = 1'b0;
  localparam logic       CF_RST    = 1'b0;

  // ----------------------------------------------------------------
  // instruction selector
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_FAR_MOVE_TO_ACC,
    OP_FAR_MOVE_TO_MEM,
    OP_FAR_OR_TO_ACCUMULATOR,
    OP_FAR_OR_TO_MEMORY,
    OP_FAR_ROTATE_LEFT,
    OP_FAR_ROTATE_LEFT_TO_ACCUMULATOR,
    OP_FAR_ROTATE_LEFT_THROUGH_CARRY,
    OP_FAR_ROTATE_LEFT_CARRY_TO_ACCUMULATOR
  } lamora_op_t;

  // result of one instruction, before it is registered
  typedef struct packed {
    logic [7:0] value;   // byte produced
    logic       to_acc;  // value goes to the accumulator
    logic       to_mem;  // value goes back to the memory byte
    logic       upd_z;   // zero flag follows the value
    logic       upd_c;   // carry takes c_new
    logic       c_new;   // new carry
  } lamora_res_t;

  // complete state of the datapath
  typedef struct packed {
    logic [7:0] acc;
    logic       zf;
    logic       cf;
    logic       mem_we;
    logic [7:0] mem_wdata;
    logic       done;
  } lamora_state_t;

endpackage

// ==== verilog/lamora_calc.sv ====
// combinational result logic of the far-address move, or and rotate group
`timescale 1ns/1ns
`default_nettype none

module lamora_calc (
  input  wire lamora_pkg::lamora_op_t  op,      // instruction selector
  input  wire logic [7:0]              acc,     // current accumulator
  input  wire logic [7:0]              mem,     // addressed memory byte
  input  wire logic                    carry,   // current carry flag
  output var lamora_pkg::lamora_res_t  res      // result and its routing
);
  import lamora_pkg::*;

  logic [7:1] shifted;  // bits 7..1 of a left rotate
  logic [7:0] rot_plain;
  logic [7:0] rot_carry;

  // ----------------------------------------------------------------
  // left shift body, one stage per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = LOW_BIT; gi < TOP_BIT; gi = gi + 1) begin : g_shift
      assign shifted[gi+1] = mem[gi];
    end
  endgenerate

  // low bit differs: old top bit or old carry
  assign rot_plain = {shifted, mem[TOP_BIT]};  // RULE_05
  assign rot_carry = {shifted, carry};         // RULE_07

  // ----------------------------------------------------------------
  // routing per instruction; flags left alone unless named
  // ----------------------------------------------------------------
  always_comb begin
    res = '0;
    case (op)
      OP_FAR_MOVE_TO_ACC: begin
        res.value  = mem;  // RULE_01
        res.to_acc = 1'b1;
      end
      OP_FAR_MOVE_TO_MEM: begin
        res.value  = acc;  // RULE_02
        res.to_mem = 1'b1;
      end
      OP_FAR_OR_TO_ACCUMULATOR: begin
        res.value  = acc | mem;  // RULE_03
        res.to_acc = 1'b1;
        res.upd_z  = 1'b1;
      end
      OP_FAR_OR_TO_MEMORY: begin
        res.value  = acc | mem;  // RULE_04
        res.to_mem = 1'b1;
        res.upd_z  = 1'b1;
      end
      OP_FAR_ROTATE_LEFT: begin
        res.value  = rot_plain;  // RULE_05
        res.to_mem = 1'b1;
      end
      OP_FAR_ROTATE_LEFT_TO_ACCUMULATOR: begin
        res.value  = rot_plain;  // RULE_06
        res.to_acc = 1'b1;
      end
      OP_FAR_ROTATE_LEFT_THROUGH_CARRY: begin
        res.value  = rot_carry;  // RULE_07
        res.to_mem = 1'b1;
        res.upd_c  = 1'b1;
        res.c_new  = mem[TOP_BIT];
      end
      OP_FAR_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: begin
        res.value  = rot_carry;  // RULE_08
        res.to_acc = 1'b1;
        res.upd_c  = 1'b1;
        res.c_new  = mem[TOP_BIT];
      end
      default: begin
        res = '0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== verilog/lamora_datapath.sv ====
// far-address move, or and rotate datapath with accumulator and flags
// Notes on behaviour
// RULE_01 - Move-to-accumulator loads the memory byte into the accumulator and keeps all flags.
// RULE_02 - Move-to-memory writes the accumulator into the memory byte and keeps all flags.
// RULE_03 - Or-to-accumulator puts accumulator or memory into the accumulator, touching only zero.
// RULE_04 - Or-to-memory writes accumulator or memory back to memory, touching only zero.
// RULE_05 - Plain left rotate moves bits up, old bit 7 into bit 0, writes memory, keeps flags.
// RULE_06 - Plain left rotate to accumulator puts that byte in the accumulator, memory and flags kept.
// RULE_07 - Carry left rotate fills bit 0 from carry, carry from old bit 7, writes memory.
// RULE_08 - Carry left rotate to accumulator does the same into the accumulator, memory kept.
// RULE_09 - Where zero is updated it is set for an all-zero result and cleared otherwise.
`timescale 1ns/1ns
`default_nettype none

module lamora_datapath (
  input  wire logic                   sys_clk,      // core clock, 25 MHz
  input  wire logic                   rst_n,        // async reset, low
  input  wire logic                   op_valid,     // execute op this cycle
  input  wire lamora_pkg::lamora_op_t op,           // instruction selector
  input  wire logic [7:0]             mem_rdata,    // addressed memory byte
  input  wire logic                   ext_wr_en,    // core loads acc/flags
  input  wire logic [7:0]             ext_acc,      // value for accumulator
  input  wire logic                   ext_carry,    // value for carry
  input  wire logic                   ext_zero,     // value for zero
  output logic [7:0]                  accumulator,  // accumulator register
  output logic                        zero_flag,    // zero flag register
  output logic                        carry_flag,   // carry flag register
  output logic                        mem_we,       // memory write pulse
  output logic [7:0]                  mem_wdata,    // memory write byte
  output logic                        op_done       // op retired pulse
);
  import lamora_pkg::*;

  lamora_state_t st_r;
  lamora_state_t st_nxt;
  lamora_res_t   res;

  // ----------------------------------------------------------------
  // result logic
  // ----------------------------------------------------------------
  lamora_calc u_calc (
    .op    (op),
    .acc   (st_r.acc),
    .mem   (mem_rdata),
    .carry (st_r.cf),
    .res   (res)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // an op wins over a core load in the same cycle, so the op never sees
  // its operands change under it; the core must not do both at once
  always_comb begin
    st_nxt        = st_r;
    st_nxt.mem_we = 1'b0;
    st_nxt.done   = 1'b0;
    if (op_valid && (op != OP_NONE)) begin
      st_nxt.done = 1'b1;
      if (res.to_acc) begin
        st_nxt.acc = res.value;  // RULE_01
      end
      if (res.to_mem) begin
        st_nxt.mem_we    = 1'b1;  // RULE_02
        st_nxt.mem_wdata = res.value;
      end
      if (res.upd_z) begin
        st_nxt.zf = (res.value == ZERO_BYTE);  // RULE_09
      end
      if (res.upd_c) begin
        st_nxt.cf = res.c_new;  // RULE_07
      end
    end else if (ext_wr_en) begin
      st_nxt.acc = ext_acc;
      st_nxt.zf  = ext_zero;
      st_nxt.cf  = ext_carry;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.acc       <= ACC_RST;
      st_r.zf        <= ZF_RST;
      st_r.cf        <= CF_RST;
      st_r.mem_we    <= 1'b0;
      st_r.mem_wdata <= WDATA_RST;
      st_r.done      <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign accumulator = st_r.acc;
  assign zero_flag   = st_r.zf;
  assign carry_flag  = st_r.cf;
  assign mem_we      = st_r.mem_we;
  assign mem_wdata   = st_r.mem_wdata;
  assign op_done     = st_r.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_issue(lamora_op_t o);
    op_valid && (op == o);
  endsequence

  sequence s_flags_kept;
    (zero_flag == $past(zero_flag)) && (carry_flag == $past(carry_flag));
  endsequence

  sequence s_no_write;
    !mem_we;
  endsequence

  // move to accumulator: byte taken, flags kept, no write
  chk_move_to_acc: assert property ( // RULE_01
    s_issue(OP_FAR_MOVE_TO_ACC) |=>
      (accumulator == $past(mem_rdata)) ##0 s_flags_kept ##0 s_no_write)
    else $error("move to accumulator wrong");

  // move to memory: one write of the accumulator, then the strobe drops
  chk_move_to_mem: assert property ( // RULE_02
    s_issue(OP_FAR_MOVE_TO_MEM) ##1 !op_valid |->
      (mem_we && (mem_wdata == $past(accumulator))
       && (accumulator == $past(accumulator))) ##1 s_no_write)
    else $error("move to memory wrong");

  chk_move_mem_flags: assert property ( // RULE_02
    s_issue(OP_FAR_MOVE_TO_MEM) |=> s_flags_kept)
    else $error("move to memory changed a flag");

  // or into accumulator: value, carry kept, no write
  chk_or_to_acc: assert property ( // RULE_03
    s_issue(OP_FAR_OR_TO_ACCUMULATOR) |=>
      (accumulator == ($past(accumulator) | $past(mem_rdata)))
      && (carry_flag == $past(carry_flag)) && !mem_we)
    else $error("or to accumulator wrong");

  // or into memory: written byte, accumulator and carry kept
  chk_or_to_mem: assert property ( // RULE_04
    s_issue(OP_FAR_OR_TO_MEMORY) |=>
      mem_we && (mem_wdata == ($past(accumulator) | $past(mem_rdata)))
      && (accumulator == $past(accumulator))
      && (carry_flag == $past(carry_flag)))
    else $error("or to memory wrong");

  // zero flag tracks the or result exactly
  chk_zero_from_or: assert property ( // RULE_09
    op_valid && ((op == OP_FAR_OR_TO_ACCUMULATOR)
                 || (op == OP_FAR_OR_TO_MEMORY))
    |=> zero_flag == (($past(accumulator) | $past(mem_rdata)) == ZERO_BYTE))
    else $error("zero flag wrong after or");

  // plain rotate into memory
  chk_rot_to_mem: assert property ( // RULE_05
    s_issue(OP_FAR_ROTATE_LEFT) |=>
      mem_we && (mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
      && (accumulator == $past(accumulator)) ##0 s_flags_kept)
    else $error("plain rotate to memory wrong");

  // plain rotate into accumulator
  chk_rot_to_acc: assert property ( // RULE_06
    s_issue(OP_FAR_ROTATE_LEFT_TO_ACCUMULATOR) |=>
      (accumulator == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
      ##0 s_flags_kept ##0 s_no_write)
    else $error("plain rotate to accumulator wrong");

  // carry rotate into memory
  chk_rotc_to_mem: assert property ( // RULE_07
    s_issue(OP_FAR_ROTATE_LEFT_THROUGH_CARRY) |=>
      mem_we && (mem_wdata == {$past(mem_rdata[6:0]), $past(carry_flag)})
      && (carry_flag == $past(mem_rdata[7]))
      && (zero_flag == $past(zero_flag)))
    else $error("carry rotate to memory wrong");

  // carry rotate into accumulator
  chk_rotc_to_acc: assert property ( // RULE_08
    s_issue(OP_FAR_ROTATE_LEFT_CARRY_TO_ACCUMULATOR) |=>
      (accumulator == {$past(mem_rdata[6:0]), $past(carry_flag)})
      && (carry_flag == $past(mem_rdata[7])) && !mem_we)
    else $error("carry rotate to accumulator wrong");

  // an op followed by a cycle without op_valid retires exactly one cycle later as a single pulse
  chk_done_pulse: assert property (
    op_valid && (op != OP_NONE) ##1 !op_valid |-> op_done ##1 !op_done)
    else $error("done pulse wrong");

  // a core load lands one cycle later and retires nothing
  chk_ext_load: assert property (
    ext_wr_en && !(op_valid && (op != OP_NONE)) |=>
      (accumulator == $past(ext_acc)) && (zero_flag == $past(ext_zero))
      && (carry_flag == $past(ext_carry)) && !op_done && !mem_we)
    else $error("core load wrong");

  // an empty selector retires nothing, so the core may issue it as a bubble
  chk_none_quiet: assert property (
    op_valid && (op == OP_NONE) && !ext_wr_en |=>
      !op_done && !mem_we && $stable(accumulator)
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("empty selector changed state");

  // with nothing issued the registers hold, so no flag drifts on its own
  chk_idle_hold: assert property (
    !$past(op_valid) && !$past(ext_wr_en) |->
      $stable(accumulator) && $stable(zero_flag) && $stable(carry_flag))
    else $error("registers changed while idle");

  // the write byte stands until the next memory write, so a slow memory
  // may latch it late without a holding register of its own
  chk_wdata_holds: assert property (
    !mem_we |-> $stable(mem_wdata))
    else $error("write byte changed without a write");

endmodule

`default_nettype wire
